// ==== hdl/resistive_touch_engine.sv ====
// Resistive touch engine: acquisition sequencer, transform, pressure and tag capture
`timescale 1ns/1ps
// Functional notes
// - Mode 0 stops acquisition, detection still signalled
// - Mode 1: one acquisition per write of 1
// - Mode 2: one acquisition per frame sync
// - Mode 3: acquire continuously, about 1000 per second
// - Engine drives switches, mux, ADC; posts results
// - Raw X and Y range 0 to 1023
// - Untouched raw halves read 65535
// - Six coefficients map raw to screen coordinates
// - Untouched screen halves read -32768
// - Touched screen point looked up for 8-bit tag
// - Hold coordinate pair used for tag lookup
// - Pressure lower when harder; 32767 untouched
// - Touch accepted only beyond force threshold
// - Acquire and update raw, screen and pressure only in active state
module resistive_touch_engine #(
    parameter int CONT_CYC = touch_engine_pkg::CONT_PERIOD_CYC
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic mode_wr_i,
    input wire logic [1:0] mode_wdata_i,
    output logic [1:0] mode_o,
    input wire logic active_i,
    input wire logic frame_sync_i,
    input wire touch_engine_pkg::transform_t transform_i,
    input wire logic [15:0] threshold_i,
    input wire logic pen_i,
    output logic touch_detect_o,
    output touch_engine_pkg::switch_t switch_o,
    output logic [1:0] mux_sel_o,
    output logic adc_start_o,
    input wire logic adc_done_i,
    input wire logic [touch_engine_pkg::ADC_W-1:0] adc_data_i,
    output logic tag_req_o,
    input wire logic tag_valid_i,
    input wire logic [7:0] tag_i,
    output logic [7:0] tag_o,
    output touch_engine_pkg::xy_pair_t raw_coordinate_pair_o,
    output touch_engine_pkg::xy_pair_t screen_coordinate_pair_o,
    output touch_engine_pkg::xy_pair_t lookup_coordinate_pair_o,
    output logic [15:0] contact_pressure_value_o,
    output logic busy_o
);
    import touch_engine_pkg::*;
    localparam int PW = $clog2(CONT_CYC + 1);
    localparam int SW = $clog2(SETTLE_CYC + 1);
    localparam logic [PW-1:0] CONT_RELOAD = PW'(CONT_CYC - 1);
    localparam logic [SW-1:0] SETTLE_RELOAD = SW'(SETTLE_CYC - 1);
    // Pen comparator is asynchronous: three stages, accept when last two agree
    logic pen_s1_q, pen_s2_q, pen_s3_q, pen_q, pen_d;
    always_comb
    begin
        pen_d = (pen_s2_q == pen_s3_q) ? pen_s3_q : pen_q;
    end
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pen_s1_q <= 1'b0;
            pen_s2_q <= 1'b0;
            pen_s3_q <= 1'b0;
            pen_q <= 1'b0;
        end
        else
        begin
            pen_s1_q <= pen_i;
            pen_s2_q <= pen_s1_q;
            pen_s3_q <= pen_s2_q;
            pen_q <= pen_d;
        end
    end
    // Detection is independent of the mode, so it stays valid in mode 0
    assign touch_detect_o = pen_q;
    // Control group
    acq_state_t state_q, state_d;
    logic [1:0] mode_q, mode_d, phase_q, phase_d;
    logic single_pend_q, single_pend_d, frame_pend_q, frame_pend_d;
    logic [PW-1:0] period_q, period_d;
    logic [SW-1:0] settle_q, settle_d;
    logic [ADC_W-1:0] samp_q [4];
    logic [ADC_W-1:0] samp_d [4];
    logic start_acq;
    always_comb
    begin
        state_d = state_q;
        mode_d = mode_q;
        phase_d = phase_q;
        single_pend_d = single_pend_q;
        frame_pend_d = frame_pend_q;
        period_d = (period_q != '0) ? period_q - 1'b1 : period_q;
        settle_d = settle_q;
        samp_d = samp_q;
        start_acq = 1'b0;
        if (state_q == ST_IDLE && active_i)
            unique case (mode_q)
                MODE_OFF: start_acq = 1'b0;
                MODE_SINGLE: start_acq = single_pend_q;
                MODE_FRAME: start_acq = frame_pend_q;
                MODE_CONT: start_acq = (period_q == '0);
            endcase
        if (start_acq)
        begin
            single_pend_d = 1'b0;
            frame_pend_d = 1'b0;
            period_d = CONT_RELOAD;
            phase_d = PH_X;
            settle_d = SETTLE_RELOAD;
            state_d = ST_SETTLE;
        end
        // Set wins over the clear made by a start in the same cycle
        if (frame_sync_i && mode_q == MODE_FRAME)
            frame_pend_d = 1'b1;
        if (mode_wr_i)
        begin
            mode_d = mode_wdata_i;
            single_pend_d = (mode_wdata_i == MODE_SINGLE);
            if (mode_wdata_i != MODE_FRAME)
                frame_pend_d = 1'b0;
        end
        unique case (state_q)
            ST_IDLE: ;
            ST_SETTLE:
            begin
                if (settle_q == '0)
                    state_d = ST_CONV;
                else
                    settle_d = settle_q - 1'b1;
            end
            ST_CONV: state_d = ST_WAIT;
            ST_WAIT:
            begin
                if (adc_done_i)
                begin
                    samp_d[phase_q] = adc_data_i;
                    if (phase_q == PH_Z2)
                        state_d = ST_CALC;
                    else
                    begin
                        phase_d = phase_q + 1'b1;
                        settle_d = SETTLE_RELOAD;
                        state_d = ST_SETTLE;
                    end
                end
            end
            ST_CALC: state_d = ST_POST;
            ST_POST: state_d = ST_IDLE;
        endcase
        // Leaving the active state abandons the acquisition in flight
        if (!active_i && state_q != ST_IDLE)
            state_d = ST_IDLE;
    end
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_q <= ST_IDLE;
            mode_q <= MODE_RESET;
            phase_q <= PH_X;
            single_pend_q <= 1'b0;
            frame_pend_q <= 1'b0;
            period_q <= '0;
            settle_q <= '0;
            samp_q <= '{default: '0};
        end
        else
        begin
            state_q <= state_d;
            mode_q <= mode_d;
            phase_q <= phase_d;
            single_pend_q <= single_pend_d;
            frame_pend_q <= frame_pend_d;
            period_q <= period_d;
            settle_q <= settle_d;
            samp_q <= samp_d;
        end
    end
    // Axis drive per phase: X plate for X, Y plate for Y, Y+ to X- for pressure
    always_comb
    begin
        switch_o = '0;
        if (state_q == ST_SETTLE || state_q == ST_CONV || state_q == ST_WAIT)
            unique case (phase_q)
                PH_X: switch_o = '{xp_high: 1'b1, xm_low: 1'b1, yp_high: 1'b0, ym_low: 1'b0};
                PH_Y: switch_o = '{xp_high: 1'b0, xm_low: 1'b0, yp_high: 1'b1, ym_low: 1'b1};
                PH_Z1, PH_Z2:
                    switch_o = '{xp_high: 1'b0, xm_low: 1'b1, yp_high: 1'b1, ym_low: 1'b0};
            endcase
    end
    assign mux_sel_o = phase_q;
    assign adc_start_o = (state_q == ST_CONV);
    assign mode_o = mode_q;
    assign busy_o = (state_q != ST_IDLE);
    // Transform, kept wide so no partial sum can overflow
    logic signed [ADC_W:0] xs, ys;
    logic signed [44:0] sx, sy;
    logic [15:0] rz_calc;
    logic touched;
    always_comb
    begin
        xs = $signed({1'b0, samp_q[PH_X]});
        ys = $signed({1'b0, samp_q[PH_Y]});
        sx = 45'(transform_i.a * xs) + 45'(transform_i.b * ys) + 45'(transform_i.c);
        sy = 45'(transform_i.d * xs) + 45'(transform_i.e * ys) + 45'(transform_i.f);
        // Z2-Z1 shrinks as contact resistance falls, so harder reads lower
        rz_calc = (samp_q[PH_Z2] > samp_q[PH_Z1]) ?
            16'(samp_q[PH_Z2] - samp_q[PH_Z1]) : 16'h0000;
        touched = pen_q && (rz_calc < threshold_i);
    end
    // Result group
    xy_pair_t raw_q, raw_d, scr_q, scr_d, calc_q, calc_d, look_q, look_d;
    logic [15:0] rz_q, rz_d, rzc_q, rzc_d;
    logic [7:0] tag_q, tag_d;
    logic touched_q, touched_d, tag_req_q, tag_req_d;
    logic post_en;
    assign post_en = (state_q == ST_POST) && active_i;
    always_comb
    begin
        raw_d = raw_q;
        scr_d = scr_q;
        calc_d = calc_q;
        look_d = look_q;
        rz_d = rz_q;
        rzc_d = rzc_q;
        tag_d = tag_q;
        touched_d = touched_q;
        tag_req_d = 1'b0;
        if (state_q == ST_CALC)
        begin
            touched_d = touched;
            calc_d = '{x: sx[FRAC_BITS+15:FRAC_BITS], y: sy[FRAC_BITS+15:FRAC_BITS]};
            rzc_d = rz_calc;
        end
        if (post_en)
            if (touched_q)
            begin
                raw_d = '{x: 16'(samp_q[PH_X]), y: 16'(samp_q[PH_Y])};
                scr_d = calc_q;
                rz_d = rzc_q;
                tag_req_d = 1'b1;
            end
            else
            begin
                raw_d = '{x: RAW_IDLE, y: RAW_IDLE};
                scr_d = '{x: SCREEN_IDLE, y: SCREEN_IDLE};
                rz_d = RZ_IDLE;
            end
        // Lookup takes a frame; the point it used is kept beside its tag
        if (tag_req_q)
            look_d = scr_q;
        if (tag_valid_i)
            tag_d = tag_i;
    end
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            raw_q <= '{x: RAW_IDLE, y: RAW_IDLE};
            scr_q <= '{x: SCREEN_IDLE, y: SCREEN_IDLE};
            calc_q <= '{x: SCREEN_IDLE, y: SCREEN_IDLE};
            look_q <= '{x: SCREEN_IDLE, y: SCREEN_IDLE};
            rz_q <= RZ_IDLE;
            rzc_q <= RZ_IDLE;
            tag_q <= TAG_RESET;
            touched_q <= 1'b0;
            tag_req_q <= 1'b0;
        end
        else
        begin
            raw_q <= raw_d;
            scr_q <= scr_d;
            calc_q <= calc_d;
            look_q <= look_d;
            rz_q <= rz_d;
            rzc_q <= rzc_d;
            tag_q <= tag_d;
            touched_q <= touched_d;
            tag_req_q <= tag_req_d;
        end
    end
    assign raw_coordinate_pair_o = raw_q;
    assign screen_coordinate_pair_o = scr_q;
    assign lookup_coordinate_pair_o = look_q;
    assign contact_pressure_value_o = rz_q;
    assign tag_o = tag_q;
    assign tag_req_o = tag_req_q;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    a_off_no_start: assert property (mode_q == MODE_OFF |-> !start_acq)
        else $error("acquisition started in mode 0");
    a_single_write_start: assert property (
        mode_wr_i && mode_wdata_i == MODE_SINGLE && state_q == ST_IDLE && !start_acq
        ##1 active_i && !mode_wr_i |-> start_acq)
        else $error("single write did not start acquisition");
    a_single_no_repeat: assert property (
        start_acq && mode_q == MODE_SINGLE && !mode_wr_i |=> !start_acq [*8])
        else $error("single mode acquired twice for one write");
    a_frame_sync_start: assert property (
        frame_sync_i && mode_q == MODE_FRAME && !mode_wr_i && state_q == ST_IDLE && !start_acq
        ##1 active_i |-> start_acq)
        else $error("frame sync did not start acquisition");
    a_cont_restart: assert property (
        mode_q == MODE_CONT && period_q == '0 && state_q == ST_IDLE && active_i |-> start_acq)
        else $error("continuous mode did not restart");
    a_adc_after_settle: assert property (
        adc_start_o |-> $past(state_q) == ST_SETTLE && switch_o != '0)
        else $error("ADC started without settled axis drive");
    a_raw_range: assert property (post_en && touched_q |=> raw_q.x <= RAW_MAX &&
        raw_q.y <= RAW_MAX)
        else $error("raw coordinate out of range");
    a_untouched_values: assert property (post_en && !touched_q |=>
        raw_q == {RAW_IDLE, RAW_IDLE} && scr_q == {SCREEN_IDLE, SCREEN_IDLE} && rz_q == RZ_IDLE)
        else $error("untouched result values wrong");
    a_lookup_pair: assert property (tag_req_q |=> look_q == scr_q)
        else $error("lookup pair differs from posted screen pair");
    a_threshold_gate: assert property (post_en && touched_q |=> rz_q < threshold_i ||
        $changed(threshold_i))
        else $error("touch accepted below force threshold");
    a_inactive_hold: assert property (!active_i |=> $stable(raw_q) && $stable(scr_q) &&
        $stable(rz_q) && state_q == ST_IDLE)
        else $error("results changed outside active state");
    c_single_acq: cover property (start_acq && mode_q == MODE_SINGLE);
    c_frame_acq: cover property (start_acq && mode_q == MODE_FRAME);
    c_cont_acq: cover property (start_acq && mode_q == MODE_CONT);
    c_touched_post: cover property (post_en && touched_q ##1 tag_req_q);
endmodule // resistive_touch_engine

// ==== include/touch_engine_pkg.sv ====
// Constants, field layouts and types of the resistive touch engine
package touch_engine_pkg;
    localparam int CLK_HZ = 40_000_000;
    localparam int CLK_MHZ = CLK_HZ / 1_000_000;
    localparam int ADC_W = 10;
    localparam int FRAC_BITS = 16;
    localparam int SCREEN_LSB = 16;
    // Acquisition mode field encodings
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_SINGLE = 2'h1;
    localparam logic [1:0] MODE_FRAME = 2'h2;
    localparam logic [1:0] MODE_CONT = 2'h3;
    localparam logic [1:0] MODE_RESET = MODE_OFF;
    // Continuous mode repeat time, about one thousand per second
    localparam int CONT_PERIOD_US = 1000;
    localparam int CONT_PERIOD_CYC = CONT_PERIOD_US * CLK_MHZ;
    // Panel settle time after switching axes, rounded up
    localparam int SETTLE_NS = 2000;
    localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
    // Result values shown while untouched and after reset, and the raw coordinate maximum
    localparam logic [15:0] RAW_IDLE = 16'hFFFF;
    localparam logic [15:0] SCREEN_IDLE = 16'h8000;
    localparam logic [15:0] RZ_IDLE = 16'h7FFF;
    localparam logic [15:0] RAW_MAX = 16'h03FF;
    localparam logic [7:0] TAG_RESET = 8'h00;
    // Measurement phases; the mux code equals the phase
    localparam logic [1:0] PH_X = 2'h0;
    localparam logic [1:0] PH_Y = 2'h1;
    localparam logic [1:0] PH_Z1 = 2'h2;
    localparam logic [1:0] PH_Z2 = 2'h3;

    typedef struct packed {
        logic [15:0] x;
        logic [15:0] y;
    } xy_pair_t;

    typedef struct packed {
        logic signed [31:0] a;
        logic signed [31:0] b;
        logic signed [31:0] c;
        logic signed [31:0] d;
        logic signed [31:0] e;
        logic signed [31:0] f;
    } transform_t;

    typedef struct packed {
        logic xp_high;
        logic xm_low;
        logic yp_high;
        logic ym_low;
    } switch_t;

    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_SETTLE = 6'b000010,
        ST_CONV = 6'b000100,
        ST_WAIT = 6'b001000,
        ST_CALC = 6'b010000,
        ST_POST = 6'b100000
    } acq_state_t;
endpackage

// ==== bench/panel_model.sv ====
// Behavioural panel, axis switches, ADC and tag lookup partner
`timescale 1ns/1ps
module panel_model
    import touch_engine_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic adc_start_i,
    input wire logic [1:0] mux_sel_i,
    input wire touch_engine_pkg::switch_t switch_i,
    input wire logic tag_req_i,
    input wire logic [ADC_W*4-1:0] sample_i,
    input wire logic [7:0] tag_val_i,
    output logic adc_done_o,
    output logic [ADC_W-1:0] adc_data_o,
    output logic tag_valid_o,
    output logic [7:0] tag_o
);
    logic [2:0] cnt_q;
    logic conv_q;
    logic [1:0] ph_q;
    logic [1:0] tag_q;
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            {cnt_q, conv_q, ph_q, tag_q, adc_done_o, tag_valid_o} <= '0;
            adc_data_o <= '0;
            tag_o <= '0;
        end
        else
        begin
            adc_done_o <= 1'b0;
            tag_q <= {tag_q[0], tag_req_i};
            tag_valid_o <= tag_q[1];
            tag_o <= tag_q[1] ? tag_val_i : ~tag_o;
            if (adc_start_i)
            begin
                conv_q <= 1'b1;
                cnt_q <= 3'h3;
                ph_q <= mux_sel_i;
            end
            else if (conv_q && cnt_q == 3'h0)
            begin
                conv_q <= 1'b0;
                adc_done_o <= 1'b1;
                // Undriven panel reads garbage, not the sample
                adc_data_o <= (switch_i != 4'h0) ? sample_i[(3-ph_q)*ADC_W +: ADC_W]
                    : ~adc_data_o;
            end
            else if (conv_q)
                cnt_q <= cnt_q - 3'h1;
            else
                adc_data_o <= ~adc_data_o;
        end
    end
endmodule // panel_model

// ==== bench/tb.sv ====
// Self-checking testbench of the resistive touch engine
`timescale 1ns/1ps
module tb;
    import touch_engine_pkg::*;
    localparam int CONT = 400;
    logic clk = 0, rst_n = 0, wr = 0, act = 1, sync = 0, pen = 0;
    logic [1:0] wdata = 2'h0, mode, mux;
    transform_t tf;
    logic [15:0] thr = 16'h0064, rz;
    logic det, start, done, treq, tval, busy, busy_d = 0;
    switch_t sw;
    logic [ADC_W-1:0] adc;
    logic [ADC_W*4-1:0] smp = {10'h3FF, 10'h0C8, 10'h032, 10'h050};
    logic [7:0] tag_in, tag;
    xy_pair_t raw, scr, lkp;
    int n_errors = 0, num_checks = 0, n_starts = 0, cyc = 0, t_last = 0, gap = 0;
    logic [1:0] mux_log[$];
    switch_t sw_log[$];
    always #12.5 clk = ~clk;
    resistive_touch_engine #(.CONT_CYC(CONT)) dut (.clk_i(clk), .rst_n_i(rst_n),
        .mode_wr_i(wr), .mode_wdata_i(wdata), .mode_o(mode), .active_i(act),
        .frame_sync_i(sync), .transform_i(tf), .threshold_i(thr), .pen_i(pen),
        .touch_detect_o(det), .switch_o(sw), .mux_sel_o(mux), .adc_start_o(start),
        .adc_done_i(done), .adc_data_i(adc), .tag_req_o(treq), .tag_valid_i(tval),
        .tag_i(tag_in), .tag_o(tag), .raw_coordinate_pair_o(raw),
        .screen_coordinate_pair_o(scr), .lookup_coordinate_pair_o(lkp),
        .contact_pressure_value_o(rz), .busy_o(busy));
    panel_model partner (.clk_i(clk), .rst_n_i(rst_n), .adc_start_i(start), .mux_sel_i(mux),
        .switch_i(sw), .tag_req_i(treq), .sample_i(smp), .tag_val_i(8'hA5),
        .adc_done_o(done), .adc_data_o(adc), .tag_valid_o(tval), .tag_o(tag_in));
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        busy_d <= busy;
        if (busy === 1'b1 && busy_d === 1'b0)
        begin
            n_starts <= n_starts + 1;
            gap <= cyc - t_last;
            t_last <= cyc;
        end
        if (start === 1'b1)
        begin
            mux_log.push_back(mux);
            sw_log.push_back(sw);
        end
    end
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk_num(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("[FAIL] %s exp %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_pair(input string nm, input xy_pair_t e, input xy_pair_t g);
        chk_num(nm, e, g);
    endtask
    task automatic wait_busy(input logic lvl, input int lim);
        for (int i = 0; i < lim && busy !== lvl; i++)
            @(negedge clk);
        if (busy !== lvl)
        begin
            n_errors++;
            $display("[FAIL] busy exp %b seen %b", lvl, busy);
            complete_run();
        end
    endtask
    task automatic write_mode(input logic [1:0] m);
        @(negedge clk);
        wr = 1'b1;
        wdata = m;
        @(negedge clk);
        wr = 1'b0;
    endtask
    task automatic single_run();
        write_mode(MODE_SINGLE);
        wait_busy(1'b1, 10);
        wait_busy(1'b0, 2000);
        repeat (12) @(negedge clk);
    endtask
    task automatic t_reset();
        chk_pair("raw", 32'hFFFF_FFFF, raw);
        chk_pair("screen", 32'h8000_8000, scr);
        chk_num("pressure", 32'h7FFF, rz);
        chk_num("mode", MODE_OFF, mode);
    endtask
    task automatic t_off();
        int s0;
        pen = 1'b1;
        write_mode(MODE_OFF);
        s0 = n_starts;
        repeat (8) @(negedge clk);
        chk_num("detect", 1, det);
        sync = 1'b1;
        @(negedge clk);
        sync = 1'b0;
        repeat (600) @(negedge clk);
        chk_num("starts off", s0, n_starts);
    endtask
    task automatic t_single();
        int s0 = n_starts;
        mux_log.delete();
        sw_log.delete();
        single_run();
        chk_num("mode", MODE_SINGLE, mode);
        chk_num("starts one", s0 + 1, n_starts);
        chk_num("phases", 4, mux_log.size());
        foreach (mux_log[i])
            chk_num("mux", i, mux_log[i]);
        foreach (sw_log[i])
            chk_num("switch", (i == 0) ? 32'hC : (i == 1) ? 32'h3 : 32'h6, sw_log[i]);
        chk_pair("raw", 32'h03FF_00C8, raw);
        chk_pair("screen", 32'h0867_FF9C, scr);
        chk_num("pressure", 32'h001E, rz);
        chk_num("tag", 8'hA5, tag);
        chk_pair("lookup", 32'h0867_FF9C, lkp);
        repeat (500) @(negedge clk);
        chk_num("starts once", s0 + 1, n_starts);
    endtask
    task automatic t_thresh();
        thr = 16'h001E;
        single_run();
        chk_pair("raw", 32'hFFFF_FFFF, raw);
        chk_pair("screen", 32'h8000_8000, scr);
        chk_num("pressure", 32'h7FFF, rz);
        thr = 16'h0064;
    endtask
    task automatic t_frame();
        int s0;
        write_mode(MODE_FRAME);
        s0 = n_starts;
        repeat (3)
        begin
            sync = 1'b1;
            @(negedge clk);
            sync = 1'b0;
            repeat (600) @(negedge clk);
        end
        chk_num("starts frame", s0 + 3, n_starts);
    endtask
    task automatic t_cont();
        write_mode(MODE_CONT);
        repeat (1500) @(negedge clk);
        chk_num("period", CONT, gap);
        write_mode(MODE_OFF);
        wait_busy(1'b0, 2000);
    endtask
    task automatic t_inactive();
        int s0 = n_starts;
        act = 1'b0;
        write_mode(MODE_SINGLE);
        repeat (200) @(negedge clk);
        chk_num("starts idle", s0, n_starts);
        smp[39:30] = 10'h100;
        act = 1'b1;
        wait_busy(1'b1, 10);
        repeat (100) @(negedge clk);
        act = 1'b0;
        repeat (2) @(negedge clk);
        chk_num("abort", 0, busy);
        repeat (400) @(negedge clk);
        chk_pair("raw kept", 32'h03FF_00C8, raw);
        act = 1'b1;
    endtask
    initial
    begin
        tf = '{a: 32'h0002_0000, b: 32'h0000_8000, c: 32'h0005_0000,
            d: 32'h0, e: 32'h0001_0000, f: 32'hFED4_0000};
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        t_reset();
        t_off();
        t_single();
        t_thresh();
        t_frame();
        t_cont();
        t_single();
        t_inactive();
        complete_run();
    end
endmodule // tb
